// ### design/launch_measure_sequencer.v
// Launch measurement sequencer: begin, payload and finish handling behind a Wishbone slave.
//
// The address map and the Wishbone interface to the registers were decided locally.
`include "launch_measure_regs.vh"
`timescale 1ns/10ps
`default_nettype none

module launch_measure_sequencer #(
	parameter CMDBUF_WORDS = 32,
	parameter CMDBUF_AW = 5,
	parameter TIMEOUT_SOFT_CYC = `T_SOFT_US * `CLK_MHZ,
	parameter TIMEOUT_LONG_CYC = `T_LONG_US * `CLK_MHZ
) (
	input wire clk,
	input wire reset_n,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [15:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output wire wb_ack_o,
	output reg hash_start,
	output reg hash_target_launch,
	output reg hash_data_valid,
	output reg [7:0] hash_data,
	input wire hash_data_ready,
	output reg hash_finish,
	output reg launch_regs_reset,
	input wire hash_done,
	input wire hash_error,
	output wire fault_state
);

	////////////////////////////////////////////////////////////////////////////////
	localparam S_IDLE = 3'h0;
	localparam S_ACK = 3'h1;
	localparam S_STREAM = 3'h2;
	localparam S_FEED = 3'h3;
	localparam S_FINISH = 3'h4;
	localparam S_DONE_WAIT = 3'h5;

	reg [2:0] state_reg;
	reg [2:0] active_loc_reg;
	reg started_reg;
	reg launch_seen_reg;
	reg cleared_early_reg;
	reg seq_active_reg;
	reg excl_reg;
	reg fault_reg;
	reg slow_reg;
	reg [7:0] wbuf_count_reg;
	reg mode_buffer_reg;
	reg clr_early_reg;
	reg [15:0] startup_rc_reg;
	reg stream_mode_reg;
	reg finish_pending_reg;
	reg [15:0] remain_reg;
	reg [CMDBUF_AW+1:0] byte_idx_reg;
	reg [31:0] timer_reg;

	wire req = wb_cyc_i & wb_stb_i & (state_reg == S_IDLE);
	wire [2:0] loc = wb_adr_i[`ADR_LOC_HI:`ADR_LOC_LO];
	wire [11:0] off = wb_adr_i[`ADR_OFF_HI:`ADR_OFF_LO];
	wire loc_ok = (active_loc_reg == loc);
	wire is_cmdbuf = (off >= `OFF_CMDBUF) &&
		(off < `OFF_CMDBUF + CMDBUF_WORDS * 4);
	wire [CMDBUF_AW-1:0] buf_widx = off[CMDBUF_AW+1:2];
	wire at_top = (loc == `LOC_4);

	// Wait states are the only throttle: ack stays low while the engine is busy.
	assign wb_ack_o = (state_reg == S_ACK);
	assign fault_state = fault_reg;

	// Command decode of the three sequence actions in either interface style.
	wire fifo_begin = wb_we_i && at_top && !mode_buffer_reg && (off == `OFF_BEGIN);
	wire fifo_pay = wb_we_i && at_top && !mode_buffer_reg && (off == `OFF_PAYLOAD);
	wire fifo_fin = wb_we_i && at_top && !mode_buffer_reg && (off == `OFF_FINISH);
	wire top_wr = wb_we_i && at_top && mode_buffer_reg && (off == `OFF_TOPCTRL);
	wire buf_begin = top_wr && wb_sel_i[0] && wb_dat_i[`TOP_BEGIN_BIT];
	wire buf_data = top_wr && wb_sel_i[0] && wb_dat_i[`TOP_DATA_BIT];
	wire buf_fin = top_wr && wb_sel_i[0] && wb_dat_i[`TOP_FINISH_BIT];
	wire any_begin = fifo_begin || buf_begin;
	wire begin_ok = (active_loc_reg == `LOC_NONE) || (active_loc_reg == `LOC_4);

	// Current byte of the command buffer; lane n of a word holds byte n.
	wire [31:0] word_rd, cur_word, head_word;
	wire [7:0] cur_byte = cur_word[8 * byte_idx_reg[1:0] +: 8];
	wire [15:0] buf_len = {head_word[7:0], head_word[15:8]};

	wire [31:0] status_word = {8'h00, wbuf_count_reg, 4'h0, slow_reg, fault_reg,
		seq_active_reg, hash_target_launch, started_reg, launch_seen_reg,
		excl_reg, mode_buffer_reg, 1'b0, active_loc_reg};

	////////////////////////////////////////////////////////////////////////////////
	// Command buffer: byte-lane writes from the locality that owns the device.
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : lane
			reg [7:0] mem [0:CMDBUF_WORDS-1];
			always @(posedge clk) begin
				if (req && wb_we_i && is_cmdbuf && loc_ok && wb_sel_i[g] && !fault_reg) begin
					mem[buf_widx] <= wb_dat_i[8*g+7:8*g];
				end
			end
			assign word_rd[8*g+7:8*g] = mem[buf_widx];
			assign cur_word[8*g+7:8*g] = mem[byte_idx_reg[CMDBUF_AW+1:2]];
			assign head_word[8*g+7:8*g] = mem[0];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Main sequencer.
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= S_IDLE;
			active_loc_reg <= `LOC_NONE;
			started_reg <= 1'b0;
			launch_seen_reg <= 1'b0;
			cleared_early_reg <= 1'b0;
			seq_active_reg <= 1'b0;
			excl_reg <= 1'b0;
			fault_reg <= 1'b0;
			slow_reg <= 1'b0;
			wbuf_count_reg <= 8'h00;
			mode_buffer_reg <= 1'b0;
			clr_early_reg <= 1'b0;
			startup_rc_reg <= `RC_OK;
			stream_mode_reg <= 1'b0;
			finish_pending_reg <= 1'b0;
			remain_reg <= 16'h0000;
			byte_idx_reg <= {(CMDBUF_AW+2){1'b0}};
			timer_reg <= 32'h00000000;
			wb_dat_o <= 32'h00000000;
			hash_start <= 1'b0;
			hash_target_launch <= 1'b0;
			hash_data_valid <= 1'b0;
			hash_data <= 8'h00;
			hash_finish <= 1'b0;
			launch_regs_reset <= 1'b0;
		end else begin
			hash_start <= 1'b0;
			hash_finish <= 1'b0;
			launch_regs_reset <= 1'b0;
			if (state_reg == S_IDLE) begin
				timer_reg <= 32'h00000000;
			end else begin
				timer_reg <= timer_reg + 32'h00000001;
			end
			case (state_reg)
				S_IDLE: begin
					if (req) begin
						state_reg <= S_ACK;
						wb_dat_o <= 32'h00000000;
						if (seq_active_reg) begin
							// Inside a sequence everything else except command buffer writes is acked and dropped.
							if (fifo_pay) begin
								hash_data <= wb_dat_i[7:0];
								hash_data_valid <= 1'b1;
								stream_mode_reg <= 1'b0;
								state_reg <= S_FEED;
							end else if (fifo_fin) begin
								state_reg <= S_FINISH;
							end else if (buf_data) begin
								remain_reg <= buf_len;
								byte_idx_reg <= {{CMDBUF_AW{1'b0}}, 2'h2};
								finish_pending_reg <= buf_fin;
								stream_mode_reg <= 1'b1;
								if (buf_len > CMDBUF_WORDS * 4 - 2) begin
									fault_reg <= 1'b1;
									seq_active_reg <= 1'b0;
									active_loc_reg <= `LOC_NONE;
									wbuf_count_reg <= 8'h00;
								end else begin
									state_reg <= S_STREAM;
								end
							end else if (buf_fin) begin
								state_reg <= S_FINISH;
							end
						end else if (any_begin) begin
							// A FIFO-style begin carries no data, only the address selects it; a buffer-style begin is bit TOP_BEGIN_BIT of a TOPCTRL write.
							if (begin_ok && !fault_reg) begin
								active_loc_reg <= `LOC_4;
								seq_active_reg <= 1'b1;
								excl_reg <= 1'b0;
								if (!mode_buffer_reg) begin
									wbuf_count_reg <= 8'h00;
								end
								// Before startup the static variant extends register 0.
								hash_target_launch <= started_reg;
								hash_start <= 1'b1;
								cleared_early_reg <= 1'b0;
								if (clr_early_reg && started_reg) begin
									launch_seen_reg <= 1'b0;
									cleared_early_reg <= 1'b1;
								end
							end
						end else if (wb_we_i) begin
							case (off)
								`OFF_CONFIG: begin
									if (wb_sel_i[0]) begin
										mode_buffer_reg <= wb_dat_i[`CFG_MODE_BIT];
										clr_early_reg <= wb_dat_i[`CFG_CLR_EARLY_BIT];
									end
								end
								`OFF_STARTUP: begin
									if ((loc == `LOC_0) || (loc == `LOC_3)) begin
										startup_rc_reg <= `RC_OK;
										started_reg <= 1'b1;
										launch_seen_reg <= 1'b1;
									end else begin
										startup_rc_reg <= `RC_WRONG_LOCALITY;
									end
								end
								`OFF_LOC_REQ: begin
									if (wb_dat_i[`LREQ_CLAIM_BIT] && active_loc_reg == `LOC_NONE) begin
										active_loc_reg <= loc;
									end else if (wb_dat_i[`LREQ_DROP_BIT] && loc_ok) begin
										active_loc_reg <= `LOC_NONE;
										wbuf_count_reg <= 8'h00;
										excl_reg <= 1'b0;
									end
								end
								`OFF_EXCL: begin
									if (loc_ok) begin
										excl_reg <= wb_dat_i[0];
									end
								end
								`OFF_WBUF: begin
									if (loc_ok && wbuf_count_reg != 8'hff) begin
										wbuf_count_reg <= wbuf_count_reg + 8'h01;
									end
								end
								default: begin
								end
							endcase
						end else begin
							case (off)
								`OFF_STATUS: wb_dat_o <= status_word;
								`OFF_CONFIG: wb_dat_o <= {30'h00000000, clr_early_reg,
									mode_buffer_reg};
								`OFF_STARTUP: wb_dat_o <= {16'h0000, startup_rc_reg};
								default: begin
									if (is_cmdbuf) begin
										wb_dat_o <= word_rd;
									end
								end
							endcase
						end
					end
				end
				S_STREAM: begin
					if (remain_reg == 16'h0000) begin
						state_reg <= finish_pending_reg ? S_FINISH : S_ACK;
					end else begin
						hash_data <= cur_byte;
						hash_data_valid <= 1'b1;
						state_reg <= S_FEED;
					end
				end
				S_FEED: begin
					if (hash_data_ready) begin
						hash_data_valid <= 1'b0;
						if (stream_mode_reg) begin
							remain_reg <= remain_reg - 16'h0001;
							byte_idx_reg <= byte_idx_reg + {{(CMDBUF_AW+1){1'b0}}, 1'b1};
							state_reg <= S_STREAM;
						end else begin
							state_reg <= S_ACK;
						end
					end
				end
				S_FINISH: begin
					// The reset of launch registers precedes the extend in the engine.
					if (hash_target_launch) begin
						launch_regs_reset <= 1'b1;
					end
					hash_finish <= 1'b1;
					state_reg <= S_DONE_WAIT;
				end
				S_DONE_WAIT: begin
					if (hash_done) begin
						if (hash_target_launch && !cleared_early_reg) begin
							launch_seen_reg <= 1'b0;
						end
						active_loc_reg <= `LOC_NONE;
						wbuf_count_reg <= 8'h00;
						seq_active_reg <= 1'b0;
						state_reg <= S_ACK;
					end
				end
				S_ACK: begin
					state_reg <= S_IDLE;
				end
				default: begin
					state_reg <= S_IDLE;
				end
			endcase
			// A slow answer is flagged; the long limit is a hard failure.
			if (state_reg != S_IDLE && state_reg != S_ACK) begin
				if (timer_reg == TIMEOUT_SOFT_CYC) begin
					slow_reg <= 1'b1;
				end
				if (hash_error || timer_reg == TIMEOUT_LONG_CYC - 2) begin
					fault_reg <= 1'b1;
					active_loc_reg <= `LOC_NONE;
					wbuf_count_reg <= 8'h00;
					seq_active_reg <= 1'b0;
					hash_data_valid <= 1'b0;
					state_reg <= S_ACK;
				end
			end
		end
	end

endmodule // launch_measure_sequencer

`default_nettype wire

// ### dv/hash_engine_model.sv
// Behavioural hash engine that records every byte handed to it.
`timescale 1ns/10ps
`default_nettype none
module hash_engine_model (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic hash_start,
	input wire logic hash_data_valid,
	input wire logic [7:0] hash_data,
	input wire logic hash_finish,
	input wire logic err_req,
	output logic hash_data_ready,
	output logic hash_done,
	output logic hash_error
);
	logic [7:0] got[$];
	logic [2:0] ph;
	logic [2:0] dly;
	// Ready drops on some phases so the sequencer must hold its byte.
	assign hash_data_ready = ph[0] | ph[2];
	assign hash_error = err_req & hash_data_valid;
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ph <= 3'h0;
			dly <= 3'h0;
			hash_done <= 1'b0;
		end else begin
			ph <= ph + 3'h1;
			hash_done <= (dly == 3'h1);
			dly <= hash_finish ? 3'h4 : (dly != 3'h0 ? dly - 3'h1 : 3'h0);
			if (hash_start)
				got.delete();
			if (hash_data_valid && hash_data_ready)
				got.push_back(hash_data);
		end
	end
endmodule // hash_engine_model
`default_nettype wire

// ### dv/launch_measure_sequencer_bench.sv
// Self-checking testbench of the launch measurement sequencer.
`include "launch_measure_regs.vh"
`timescale 1ns/10ps
`default_nettype none
module launch_measure_sequencer_bench;
	logic clk = 0, reset_n = 0, cyc = 0, stb = 0, we = 0, err_req = 0, st_seen = 0, lr_seen = 0;
	logic [15:0] adr = 0;
	logic [3:0] sel = 0;
	logic [31:0] dat = 0, rd, x = 22;
	logic [7:0] q[$];
	wire [31:0] dato;
	wire [7:0] hd;
	wire ack, hs, tl, dv, hf, lr, dn, he, rdy, ft;
	int err_total = 0, cmp_count = 0, cyc_n = 0;
	initial forever #2.5 clk = ~clk;
	launch_measure_sequencer #(.TIMEOUT_SOFT_CYC(20), .TIMEOUT_LONG_CYC(40)) u_dut (.clk(clk),
		.reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dato), .wb_ack_o(ack), .hash_start(hs),
		.hash_target_launch(tl), .hash_data_valid(dv), .hash_data(hd), .hash_data_ready(rdy),
		.hash_finish(hf), .launch_regs_reset(lr), .hash_done(dn), .hash_error(he),
		.fault_state(ft));
	hash_engine_model u_eng (.clk(clk), .reset_n(reset_n), .hash_start(hs),
		.hash_data_valid(dv), .hash_data(hd), .hash_finish(hf), .err_req(err_req),
		.hash_data_ready(rdy), .hash_done(dn), .hash_error(he));
	// Pulse catchers run on the pulse itself, so a check made right after ack already sees it.
	always @(posedge hs) st_seen = 1;
	always @(posedge lr) lr_seen = 1;
	always @(posedge clk) begin
		cyc_n++;
		if (cyc_n == 20000) begin
			err_total++;
			results();
		end
	end
	////////////////////////////////////////
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction
	function automatic logic [15:0] ad(input int l, input logic [11:0] o);
		return {1'b0, l[2:0], o};
	endfunction
	task chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task wb(input logic w, input logic [15:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		{cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, 4'hf};
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 200);
		rd = dato;
		{cyc, stb} <= 2'b00;
		if (n >= 200) begin
			err_total++;
			results();
		end
	endtask
	task payload(input int n);
		repeat (n) begin
			x = xs(x);
			q.push_back(x[7:0]);
			wb(1, ad(4, `OFF_PAYLOAD), x);
		end
	endtask
	task cmpq;
		chk(32'(u_eng.got.size()), 32'(q.size()));
		foreach (q[i]) chk(u_eng.got[i], q[i]);
	endtask
	task results;
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		repeat (16) @(posedge clk);
		reset_n <= 1;
		x = xs(x);
		wb(1, ad(4, `OFF_BEGIN), x);
		chk(st_seen, 1);
		chk(tl, 0);
		payload(3);
		wb(1, ad(4, `OFF_FINISH), x);
		cmpq();
		chk(lr_seen, 0);
		wb(0, ad(0, `OFF_STATUS), 0);
		chk(rd[2:0], `LOC_NONE);
		$display("test static done");
		for (int l = 0; l < 5; l++) begin
			wb(1, ad(l, `OFF_STARTUP), 0);
			wb(0, ad(l, `OFF_STARTUP), 0);
			chk(rd[15:0], (l == 0 || l == 3) ? `RC_OK : `RC_WRONG_LOCALITY);
		end
		wb(0, ad(0, `OFF_STATUS), 0);
		chk(rd[7:6], 2'b11);
		$display("test startup done");
		st_seen = 0;
		wb(1, ad(0, `OFF_LOC_REQ), 1);
		wb(1, ad(4, `OFF_BEGIN), 0);
		chk(st_seen, 0);
		wb(0, ad(0, `OFF_STATUS), 0);
		chk(rd[2:0], `LOC_0);
		wb(1, ad(0, `OFF_LOC_REQ), 2);
		$display("test busy locality done");
		q.delete();
		wb(1, ad(4, `OFF_BEGIN), x);
		chk(tl, 1);
		wb(0, ad(4, `OFF_STATUS), 0);
		chk(rd, 0);
		wb(1, ad(4, `OFF_CONFIG), 1);
		payload(4);
		wb(1, ad(4, `OFF_FINISH), 0);
		cmpq();
		chk(lr_seen, 1);
		wb(0, ad(0, `OFF_STATUS), 0);
		chk({rd[6], rd[4], rd[2:0]}, {2'b00, `LOC_NONE});
		$display("test dynamic done");
		q.delete();
		wb(1, ad(0, `OFF_CONFIG), 1);
		wb(1, ad(4, `OFF_TOPCTRL), 1);
		x = xs(x);
		q = {x[23:16], x[31:24]};
		wb(1, ad(4, `OFF_CMDBUF), {x[31:16], 16'h0500});
		x = xs(x);
		q = {q, x[7:0], x[15:8], x[23:16]};
		wb(1, ad(4, `OFF_CMDBUF + 12'h004), x);
		wb(1, ad(4, `OFF_TOPCTRL), 6);
		cmpq();
		$display("test buffer done");
		wb(1, ad(0, `OFF_CONFIG), 2);
		wb(1, ad(3, `OFF_STARTUP), 0);
		wb(1, ad(4, `OFF_LOC_REQ), 1);
		wb(1, ad(4, `OFF_EXCL), 1);
		wb(1, ad(4, `OFF_WBUF), 0);
		wb(1, ad(4, `OFF_WBUF), 0);
		wb(0, ad(4, `OFF_STATUS), 0);
		chk({rd[23:16], rd[6:5], rd[2:0]}, {8'h02, 2'b11, `LOC_4});
		q.delete();
		x = xs(x);
		wb(1, ad(4, `OFF_BEGIN), x);
		payload(2);
		wb(1, ad(4, `OFF_FINISH), x);
		cmpq();
		wb(0, ad(0, `OFF_STATUS), 0);
		chk({rd[23:16], rd[6:5], rd[2:0]}, {8'h00, 2'b00, `LOC_NONE});
		$display("test exclusive done");
		wb(1, ad(4, `OFF_BEGIN), 0);
		err_req <= 1;
		payload(1);
		chk(ft, 1);
		wb(0, ad(0, `OFF_STATUS), 0);
		chk(rd[2:0], `LOC_NONE);
		$display("test fault done");
		results();
	end
endmodule // launch_measure_sequencer_bench
`default_nettype wire

// ### dv/launch_measure_sequencer_properties.sv
// Port checker of the launch measurement sequencer, bound to the design.
`timescale 1ns/10ps
`default_nettype none
module launch_measure_checker (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [15:0] wb_adr_i,
	input wire logic wb_ack_o,
	input wire logic hash_start,
	input wire logic hash_target_launch,
	input wire logic hash_data_valid,
	input wire logic [7:0] hash_data,
	input wire logic hash_data_ready,
	input wire logic hash_finish,
	input wire logic launch_regs_reset,
	input wire logic fault_state
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");
	a_ack_has_request: assert property (wb_ack_o |-> wb_cyc_i && wb_stb_i)
		else $error("ack without request");
	a_request_answered: assert property ($rose(wb_stb_i) |-> ##[1:60] wb_ack_o)
		else $error("request not answered in time");
	a_start_top_loc: assert property (hash_start |-> wb_ack_o && wb_adr_i[14:12] == 3'h4)
		else $error("start without top locality begin");
	a_finish_answered: assert property (hash_finish |=> !hash_finish ##[0:59] wb_ack_o)
		else $error("finish not answered in time");
	a_launch_reset: assert property (launch_regs_reset == (hash_finish && hash_target_launch))
		else $error("launch register reset mismatch");
	a_data_held: assert property (hash_data_valid && !hash_data_ready |=>
		fault_state || (hash_data_valid && $stable(hash_data)))
		else $error("payload byte dropped while stalled");
	a_fault_sticky: assert property (fault_state |=> fault_state)
		else $error("fault state left");
	a_target_steady: assert property (hash_data_valid |-> $stable(hash_target_launch))
		else $error("target changed inside sequence");
endmodule // launch_measure_checker
bind launch_measure_sequencer launch_measure_checker u_chk (.clk, .reset_n, .wb_cyc_i,
	.wb_stb_i, .wb_adr_i, .wb_ack_o, .hash_start, .hash_target_launch, .hash_data_valid,
	.hash_data, .hash_data_ready, .hash_finish, .launch_regs_reset, .fault_state);
`default_nettype wire

// ### pkg/launch_measure_regs.vh
// Register offsets, field positions and timing constants of the launch measurement sequencer.
`ifndef LAUNCH_MEASURE_REGS_VH
`define LAUNCH_MEASURE_REGS_VH

// Byte address layout: locality in bits 14:12, register offset in bits 11:0.
`define ADR_LOC_HI 14
`define ADR_LOC_LO 12
`define ADR_OFF_HI 11
`define ADR_OFF_LO 0

// Register offsets within each locality window.
`define OFF_STATUS 12'h000
`define OFF_CONFIG 12'h004
`define OFF_STARTUP 12'h008
`define OFF_LOC_REQ 12'h00c
`define OFF_EXCL 12'h010
`define OFF_WBUF 12'h014
`define OFF_BEGIN 12'h020
`define OFF_PAYLOAD 12'h024
`define OFF_FINISH 12'h028
`define OFF_TOPCTRL 12'h040
`define OFF_CMDBUF 12'h800

// Localities.
`define LOC_NONE 3'h7
`define LOC_0 3'h0
`define LOC_3 3'h3
`define LOC_4 3'h4

// Config fields.
`define CFG_MODE_BIT 0
`define CFG_CLR_EARLY_BIT 1

// Top locality control fields.
`define TOP_BEGIN_BIT 0
`define TOP_DATA_BIT 1
`define TOP_FINISH_BIT 2

// Locality request fields.
`define LREQ_CLAIM_BIT 0
`define LREQ_DROP_BIT 1

// Startup answer codes; the error value is arbitrary.
`define RC_OK 16'h0000
`define RC_WRONG_LOCALITY 16'h0001

// Timing.
`define CLK_MHZ 200
`define T_SOFT_US 250
`define T_LONG_US 750

`endif
